// ==== inc/sldc_params.svh ====
// Constants of the serial LCD driver control block
`ifndef SLDC_PARAMS_SVH
`define SLDC_PARAMS_SVH
`define SLDC_REF_HZ 100000000
`define SLDC_RC_HZ 256000
`define SLDC_RAM_WORDS 32
`define SLDC_RAM_BITS 4
`define SLDC_ID_BITS 3
`define SLDC_ADDR_BITS 6
`define SLDC_CMD_BITS 9
`define SLDC_ID_READ 3'h6
`define SLDC_ID_WRITE 3'h5
`define SLDC_ID_CMD 3'h4
`define SLDC_PRESCALE_BITS 3
`define SLDC_DIV_BITS 7
`define SLDC_TB_BITS 8
`define SLDC_WDT_BITS 2
`define SLDC_RATE_RESET 3'h7
`define SLDC_COM_RESET 2'h2
`define SLDC_LCD_TAP 6
`define SLDC_TONE4_TAP 2
`define SLDC_TONE2_TAP 3
`define SLDC_CMD_OSC_POWER_DOWN_CMD 9'h000
`define SLDC_CMD_OSC_START_CMD 9'h002
`define SLDC_CMD_BIAS_GEN_OFF_CMD 9'h004
`define SLDC_CMD_BIAS_GEN_ON_CMD 9'h006
`define SLDC_CMD_TB_DIS 9'h008
`define SLDC_CMD_WATCHDOG_DISABLE_CMD 9'h00A
`define SLDC_CMD_TB_EN 9'h00C
`define SLDC_CMD_WATCHDOG_ENABLE_CMD 9'h00E
`define SLDC_CMD_TONE_OFF 9'h010
`define SLDC_CMD_TONE_ON 9'h012
`endif

// ==== inc/sldc_pkg.sv ====
// Types of the serial LCD driver control block
`default_nettype none
package sldc_pkg;
    typedef enum logic [3:0] {
        ST_ID = 4'h1,
        ST_CMD = 4'h2,
        ST_ADDR = 4'h4,
        ST_DATA = 4'h8
    } sldc_state_type;
    typedef enum logic [1:0] {
        SRC_XTAL = 2'h1,
        SRC_RC = 2'h2,
        SRC_EXT = 2'h3
    } sldc_src_type;
endpackage : sldc_pkg
`default_nettype wire

// ==== rtl/sldc_top.sv ====
// Serial LCD driver control: link decoder, display RAM, clocks, time base
`include "sldc_params.svh"
`default_nettype none
module sldc_top #(
    parameter int RAM_WORDS = `SLDC_RAM_WORDS
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic SEL_N,
    input wire logic WR_N,
    input wire logic RD_N,
    input wire logic DATA_I,
    output logic DATA_O,
    output logic DATA_OE,
    input wire logic OSCILLATOR_INPUT,
    output logic FLAG_N_O,
    output logic FLAG_OE,
    output logic BUZZER_DRIVE_P,
    output logic BUZZER_DRIVE_N,
    output logic [`SLDC_RAM_WORDS-1:0] FRONTPLANE_LINE,
    output logic [`SLDC_RAM_BITS-1:0] BACKPLANE_LINE,
    output logic LCD_CLK,
    output logic BIAS_ON,
    output logic BIAS_THIRD,
    output logic [1:0] BACKPLANE_COUNT,
    output logic OSC_RUNNING
);
    localparam int RC_DIV = `SLDC_REF_HZ / `SLDC_RC_HZ;
    localparam int RCW = $clog2(RC_DIV);

    // Pin synchronisers: change counts when stages two and three agree
    logic [4:0] s1_q, s2_q, s3_q, pin_q, pin_old_q;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            s1_q <= 5'h1F;
            s2_q <= 5'h1F;
            s3_q <= 5'h1F;
            pin_q <= 5'h1F;
            pin_old_q <= 5'h1F;
        end
        else
        begin
            s1_q <= {OSCILLATOR_INPUT, DATA_I, RD_N, WR_N, SEL_N};
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < 5; i++)
            begin
                if (s2_q[i] == s3_q[i])
                    pin_q[i] <= s3_q[i];
            end
            pin_old_q <= pin_q;
        end
    end
    logic sel_hi, wr_rise, rd_fall, din, osc_rise;
    assign sel_hi = pin_q[0];
    assign wr_rise = pin_q[1] & ~pin_old_q[1];
    assign rd_fall = ~pin_q[2] & pin_old_q[2];
    assign din = pin_q[3];
    assign osc_rise = pin_q[4] & ~pin_old_q[4];

    // Serial frame decoder
    sldc_pkg::sldc_state_type st_q;
    logic [2:0] id_q;
    logic [3:0] cnt_q;
    logic [`SLDC_CMD_BITS-1:0] sh_q;
    logic [`SLDC_ADDR_BITS-1:0] addr_q;
    logic [1:0] rd_idx_q;
    logic [`SLDC_CMD_BITS-1:0] cmd_q;
    logic cmd_v_q, wr_mem_q;
    logic [3:0] wr_nib_q;
    logic [3:0] mem_q [RAM_WORDS];
    logic [3:0] cur_nib;
    assign cur_nib = mem_q[addr_q[4:0]];

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            st_q <= sldc_pkg::ST_ID;
            id_q <= 3'h0;
            cnt_q <= 4'h0;
            sh_q <= '0;
            addr_q <= '0;
            rd_idx_q <= 2'h0;
            cmd_q <= '0;
            cmd_v_q <= 1'b0;
            wr_mem_q <= 1'b0;
            wr_nib_q <= 4'h0;
        end
        else
        begin
            cmd_v_q <= 1'b0;
            wr_mem_q <= 1'b0;
            if (sel_hi)
            begin
                st_q <= sldc_pkg::ST_ID;
                cnt_q <= 4'h0;
                rd_idx_q <= 2'h0;
            end
            else
            begin
                if (rd_fall && st_q == sldc_pkg::ST_DATA)
                begin
                    rd_idx_q <= rd_idx_q + 2'h1;
                    if (id_q == `SLDC_ID_READ && rd_idx_q == 2'h3)
                        addr_q <= addr_q + 6'h01;
                end
                if (wr_rise)
                begin
                    cnt_q <= cnt_q + 4'h1;
                    sh_q <= {sh_q[`SLDC_CMD_BITS-2:0], din};
                    case (st_q)
                        sldc_pkg::ST_ID:
                        begin
                            if (cnt_q == 4'h2)
                            begin
                                id_q <= {sh_q[1:0], din};
                                cnt_q <= 4'h0;
                                if ({sh_q[1:0], din} == `SLDC_ID_CMD)
                                    st_q <= sldc_pkg::ST_CMD;
                                else
                                    st_q <= sldc_pkg::ST_ADDR;
                            end
                        end
                        sldc_pkg::ST_CMD:
                        begin
                            if (cnt_q == 4'h8)
                            begin
                                cmd_q <= {sh_q[7:0], din};
                                cmd_v_q <= 1'b1;
                                cnt_q <= 4'h0;
                            end
                        end
                        sldc_pkg::ST_ADDR:
                        begin
                            if (cnt_q == 4'h5)
                            begin
                                addr_q <= {sh_q[4:0], din};
                                cnt_q <= 4'h0;
                                rd_idx_q <= 2'h0;
                                st_q <= sldc_pkg::ST_DATA;
                            end
                        end
                        sldc_pkg::ST_DATA:
                        begin
                            wr_nib_q <= {din, wr_nib_q[3:1]};
                            if (cnt_q == 4'h3)
                            begin
                                cnt_q <= 4'h0;
                                rd_idx_q <= 2'h0;
                                wr_mem_q <= (id_q == `SLDC_ID_WRITE);
                            end
                        end
                        default:
                            st_q <= sldc_pkg::ST_ID;
                    endcase
                end
                if (wr_mem_q)
                    addr_q <= addr_q + 6'h01;
            end
        end
    end

    // display RAM; address high bit ignored
    always_ff @(posedge REF_CLK)
    begin
        if (wr_mem_q)
            mem_q[addr_q[4:0]] <= wr_nib_q;
    end

    // read bit driven from read strobe fall
    logic data_o_q, data_oe_q;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST || sel_hi)
        begin
            data_o_q <= 1'b0;
            data_oe_q <= 1'b0;
        end
        else if (rd_fall && st_q == sldc_pkg::ST_DATA)
        begin
            data_o_q <= cur_nib[rd_idx_q];
            data_oe_q <= 1'b1;
        end
    end
    assign DATA_O = data_o_q;
    assign DATA_OE = data_oe_q;

    // Configuration commands
    logic osc_on_q, bias_on_q, bias_third_q, tone_on_q, tone_low_q;
    logic [1:0] com_q;
    logic [2:0] rate_q;
    sldc_pkg::sldc_src_type src_q;
    logic sys_run;
    // Trailing don't-care bit masked so either value decodes
    logic [`SLDC_CMD_BITS-1:0] cmd_k;
    assign cmd_k = {cmd_q[`SLDC_CMD_BITS-1:1], 1'b0};
    assign sys_run = osc_on_q | (src_q == sldc_pkg::SRC_EXT);
    always_ff @(posedge REF_CLK)
    begin
        // oscillator and bias off at reset
        if (SYS_RST)
        begin
            osc_on_q <= 1'b0;
            bias_on_q <= 1'b0;
            bias_third_q <= 1'b1;
            com_q <= `SLDC_COM_RESET;
            tone_on_q <= 1'b0;
            tone_low_q <= 1'b0;
            rate_q <= `SLDC_RATE_RESET;
            src_q <= sldc_pkg::SRC_RC;
        end
        else if (cmd_v_q)
        begin
            if (cmd_k == `SLDC_CMD_OSC_POWER_DOWN_CMD && src_q != sldc_pkg::SRC_EXT)
            begin
                osc_on_q <= 1'b0;
                bias_on_q <= 1'b0;
            end
            if (cmd_k == `SLDC_CMD_OSC_START_CMD)
                osc_on_q <= 1'b1;
            if (cmd_k == `SLDC_CMD_BIAS_GEN_OFF_CMD)
                bias_on_q <= 1'b0;
            if (cmd_k == `SLDC_CMD_BIAS_GEN_ON_CMD)
                bias_on_q <= 1'b1;
            if (cmd_k == `SLDC_CMD_TONE_OFF)
                tone_on_q <= 1'b0;
            if (cmd_k == `SLDC_CMD_TONE_ON)
                tone_on_q <= 1'b1;
            if (cmd_q[8:7] == 2'h1)
                tone_low_q <= cmd_q[6];
            if (cmd_q[8:5] == 4'h1 && cmd_q[4:3] != 2'h0)
                src_q <= sldc_pkg::sldc_src_type'(cmd_q[4:3]);
            if (cmd_q[8:5] == 4'h2 && cmd_q[4:3] != 2'h3)
            begin
                com_q <= cmd_q[4:3];
                bias_third_q <= cmd_q[1];
            end
            if (cmd_q[8:6] == 3'h5)
                rate_q <= cmd_q[3:1];
        end
    end

    // tick sources; 3-stage prescale of 256kHz
    logic [RCW-1:0] rc_q;
    logic [`SLDC_PRESCALE_BITS-1:0] pre_q;
    logic tick256, tick32;
    assign tick256 = sys_run & ((src_q == sldc_pkg::SRC_RC) ? (rc_q == RCW'(RC_DIV - 1)) : osc_rise);
    assign tick32 = (src_q == sldc_pkg::SRC_XTAL) ? (sys_run & osc_rise) : (tick256 && pre_q == 3'h7);
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST || !sys_run)
        begin
            rc_q <= '0;
            pre_q <= 3'h0;
        end
        else
        begin
            rc_q <= (rc_q == RCW'(RC_DIV - 1)) ? '0 : rc_q + 1'b1;
            if (tick256)
                pre_q <= pre_q + 3'h1;
        end
    end

    // Common 32kHz divider feeds LCD, tone and timer taps
    logic [`SLDC_DIV_BITS-1:0] div_q, div_nx;
    assign div_nx = div_q + 1'b1;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            div_q <= '0;
        else if (tick32)
            div_q <= div_nx;
    end

    // timer clock 32k/2^n, n = 7 - rate
    logic tmr_tick, clr_tb, watchdog_clear_cmd;
    logic [2:0] n_sel;
    assign n_sel = 3'h7 - rate_q;
    assign tmr_tick = tick32 && (n_sel == 3'h0 || (div_q[n_sel - 3'h1] && !div_nx[n_sel - 3'h1]));
    assign clr_tb = cmd_v_q && cmd_q[8:3] == 6'h03;
    assign watchdog_clear_cmd = cmd_v_q && cmd_q[8:2] == 7'h07;

    // time base and watchdog stages; run control
    logic [`SLDC_TB_BITS-1:0] tb_q;
    logic [`SLDC_WDT_BITS-1:0] wdt_q;
    logic run_q, to_flag_q, sel_wdt_q, sel_tb_q, flag_en_q;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            tb_q <= '0;
            wdt_q <= '0;
            to_flag_q <= 1'b0;
        end
        else
        begin
            // flag held until clear or pin disable
            // Clear first, so a time-out in the same cycle wins
            if (watchdog_clear_cmd || (cmd_v_q && cmd_q[8:6] == 3'h4 && !cmd_q[4]))
                to_flag_q <= 1'b0;
            if (run_q && sys_run && tmr_tick)
            begin
                tb_q <= tb_q + 1'b1;
                if (tb_q == '1)
                begin
                    wdt_q <= wdt_q + 1'b1;
                    if (wdt_q == '1)
                        to_flag_q <= 1'b1;
                end
            end
            if (clr_tb || watchdog_clear_cmd)
                tb_q <= '0;
            if (watchdog_clear_cmd)
                wdt_q <= '0;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            run_q <= 1'b0;
            sel_wdt_q <= 1'b0;
            sel_tb_q <= 1'b0;
            flag_en_q <= 1'b0;
        end
        else if (cmd_v_q)
        begin
            if (cmd_k == `SLDC_CMD_WATCHDOG_DISABLE_CMD)
            begin
                run_q <= 1'b0;
                sel_wdt_q <= 1'b0;
            end
            if (cmd_k == `SLDC_CMD_WATCHDOG_ENABLE_CMD)
            begin
                run_q <= 1'b1;
                sel_wdt_q <= 1'b1;
                sel_tb_q <= 1'b0;
            end
            if (cmd_k == `SLDC_CMD_TB_EN)
            begin
                run_q <= 1'b1;
                sel_tb_q <= 1'b1;
                sel_wdt_q <= 1'b0;
            end
            if (cmd_k == `SLDC_CMD_TB_DIS)
                sel_tb_q <= 1'b0;
            if (cmd_q[8:6] == 3'h4)
                flag_en_q <= cmd_q[4];
        end
    end

    // open-drain flag pin, floats when disabled
    logic flag_oe_q;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            flag_oe_q <= 1'b0;
        else
            flag_oe_q <= flag_en_q & ((sel_wdt_q & to_flag_q) | (sel_tb_q & sys_run & ~tb_q[`SLDC_TB_BITS-1]));
    end
    assign FLAG_OE = flag_oe_q;
    assign FLAG_N_O = 1'b0;

    // buzzer low when oscillator or tone off
    logic bz_q;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            bz_q <= 1'b0;
        else
            bz_q <= tone_on_q & sys_run & div_q[tone_low_q ? `SLDC_TONE2_TAP : `SLDC_TONE4_TAP];
    end
    // differential pair, both low when silent
    logic bzn_q;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            bzn_q <= 1'b0;
        else
            bzn_q <= tone_on_q & sys_run & ~div_q[tone_low_q ? `SLDC_TONE2_TAP : `SLDC_TONE4_TAP];
    end
    assign BUZZER_DRIVE_P = bz_q;
    assign BUZZER_DRIVE_N = bzn_q;

    // 256Hz drive clock steps the backplane scan
    logic lcd_q, bias_gen_on_cmd;
    logic [1:0] com_idx_q;
    logic [3:0] bp_q;
    logic [`SLDC_RAM_WORDS-1:0] fp_q;
    assign bias_gen_on_cmd = bias_on_q & sys_run;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            lcd_q <= 1'b0;
            com_idx_q <= 2'h0;
            bp_q <= 4'h0;
        end
        else
        begin
            lcd_q <= sys_run & div_q[`SLDC_LCD_TAP];
            if (sys_run && div_q[`SLDC_LCD_TAP] && !lcd_q)
                com_idx_q <= (com_idx_q >= com_q + 2'h1) ? 2'h0 : com_idx_q + 2'h1;
            bp_q <= bias_gen_on_cmd ? (4'h1 << com_idx_q) : 4'h0;
        end
    end
    // segment n shows word n at current backplane
    for (genvar g = 0; g < `SLDC_RAM_WORDS; g++)
    begin : g_seg
        always_ff @(posedge REF_CLK)
        begin
            if (SYS_RST)
                fp_q[g] <= 1'b0;
            else
                fp_q[g] <= bias_gen_on_cmd & mem_q[g][com_idx_q];
        end
    end
    assign FRONTPLANE_LINE = fp_q;
    assign BACKPLANE_LINE = bp_q;
    assign LCD_CLK = lcd_q;

    // Status outputs
    logic bias_q, third_q, run_o_q;
    logic [1:0] cnt_o_q;
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            bias_q <= 1'b0;
            third_q <= 1'b0;
            cnt_o_q <= 2'h0;
            run_o_q <= 1'b0;
        end
        else
        begin
            bias_q <= bias_gen_on_cmd;
            third_q <= bias_third_q;
            cnt_o_q <= com_q;
            run_o_q <= sys_run;
        end
    end
    assign BIAS_ON = bias_q;
    assign BIAS_THIRD = third_q;
    assign BACKPLANE_COUNT = cnt_o_q;
    assign OSC_RUNNING = run_o_q;
endmodule : sldc_top
`default_nettype wire

// ==== verification/sldc_top_assertions.sv ====
// Port-level assertions of the serial LCD driver control block
`include "sldc_params.svh"
`default_nettype none
module sldc_checker (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic SEL_N,
    input wire logic RD_N,
    input wire logic DATA_OE,
    input wire logic FLAG_N_O,
    input wire logic FLAG_OE,
    input wire logic BUZZER_DRIVE_P,
    input wire logic BUZZER_DRIVE_N,
    input wire logic [`SLDC_RAM_WORDS-1:0] FRONTPLANE_LINE,
    input wire logic [`SLDC_RAM_BITS-1:0] BACKPLANE_LINE,
    input wire logic BIAS_ON,
    input wire logic BIAS_THIRD,
    input wire logic [1:0] BACKPLANE_COUNT,
    input wire logic OSC_RUNNING
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);
    // Select idle long enough to pass the pin synchroniser
    sequence sel_idle;
        SEL_N [*8];
    endsequence
    sequence read_open;
        (!SEL_N) [*5] ##0 DATA_OE;
    endsequence
    a_flag_open_drain: assert property (FLAG_N_O == 1'h0)
        else $error("flag pin driven high");
    a_flag_reset_off: assert property ($fell(SYS_RST) |-> ##2 !FLAG_OE)
        else $error("flag pin enabled after reset");
    a_reset_panel_state: assert property ($fell(SYS_RST) |-> ##2
        (BIAS_THIRD && BACKPLANE_COUNT == 2'h2 && !OSC_RUNNING && !BIAS_ON))
        else $error("wrong state after reset");
    a_buzz_silent: assert property ((!OSC_RUNNING) [*4] |-> !BUZZER_DRIVE_P && !BUZZER_DRIVE_N)
        else $error("buzzer active without clock");
    a_buzz_differential: assert property (BUZZER_DRIVE_P || BUZZER_DRIVE_N |-> BUZZER_DRIVE_P != BUZZER_DRIVE_N)
        else $error("buzzer pair not differential");
    a_bias_needs_clock: assert property (BIAS_ON |-> OSC_RUNNING || $past(OSC_RUNNING))
        else $error("bias on while clock stopped");
    a_blank_display: assert property ((!BIAS_ON) [*3] |-> BACKPLANE_LINE == '0 && FRONTPLANE_LINE == '0)
        else $error("display not blank");
    a_plane_onehot: assert property (BACKPLANE_LINE != '0 |-> $onehot(BACKPLANE_LINE))
        else $error("backplane not one-hot");
    a_sel_abort: assert property (sel_idle |-> !DATA_OE)
        else $error("data driven while deselected");
    a_read_start: assert property ($rose(DATA_OE) |-> !RD_N && !SEL_N)
        else $error("data driven without read strobe");
    a_read_holds: assert property (read_open |=> DATA_OE)
        else $error("data released while selected");
endmodule : sldc_checker
bind sldc_top sldc_checker u_chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SEL_N(SEL_N), .RD_N(RD_N),
    .DATA_OE(DATA_OE), .FLAG_N_O(FLAG_N_O), .FLAG_OE(FLAG_OE), .BUZZER_DRIVE_P(BUZZER_DRIVE_P),
    .BUZZER_DRIVE_N(BUZZER_DRIVE_N), .FRONTPLANE_LINE(FRONTPLANE_LINE), .BACKPLANE_LINE(BACKPLANE_LINE),
    .BIAS_ON(BIAS_ON), .BIAS_THIRD(BIAS_THIRD), .BACKPLANE_COUNT(BACKPLANE_COUNT), .OSC_RUNNING(OSC_RUNNING));
`default_nettype wire

// ==== verification/sldc_host.sv ====
// Host controller model driving select, strobes and the data line
`default_nettype none
module sldc_host (
    input wire logic clk,
    output logic sel_n,
    output logic wr_n,
    output logic rd_n,
    output logic data_i,
    input wire logic data_o,
    input wire logic data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'h0;
    logic dv = 1'h0;
    // Host drive wins on the write half of read-modify-write; released line is pulled up
    assign data_i = drv ? dv : (data_oe ? data_o : 1'h1);
    initial
    begin
        sel_n = 1'h1;
        wr_n = 1'h1;
        rd_n = 1'h1;
    end
    task automatic sel_pulse();
        @(posedge clk);
        sel_n <= 1'h1;
        repeat (10) @(posedge clk);
        sel_n <= 1'h0;
        repeat (10) @(posedge clk);
    endtask : sel_pulse
    // data held across the write rise
    task automatic wr_bit(input logic b);
        @(posedge clk);
        wr_n <= 1'h0;
        drv <= 1'h1;
        dv <= b;
        repeat (10) @(posedge clk);
        wr_n <= 1'h1;
        repeat (10) @(posedge clk);
        drv <= 1'h0;
    endtask : wr_bit
    // sample between strobe rise and next fall
    task automatic rd_bit(output logic b);
        @(posedge clk);
        rd_n <= 1'h0;
        repeat (10) @(posedge clk);
        rd_n <= 1'h1;
        repeat (9) @(posedge clk);
        b = data_i;
    endtask : rd_bit
    task automatic send_id(input logic [2:0] v);
        for (int i = 2; i >= 0; i--) wr_bit(v[i]);
    endtask : send_id
    task automatic send_cmd(input logic [8:0] v);
        for (int i = 8; i >= 0; i--) wr_bit(v[i]);
    endtask : send_cmd
    // address A5 first, nibbles D0 first
    task automatic send_addr(input logic [5:0] v);
        for (int i = 5; i >= 0; i--) wr_bit(v[i]);
    endtask : send_addr
    task automatic send_nib(input logic [3:0] v);
        for (int i = 0; i < 4; i++) wr_bit(v[i]);
    endtask : send_nib
    task automatic read_nib(output logic [3:0] v);
        for (int i = 0; i < 4; i++) rd_bit(v[i]);
    endtask : read_nib
endmodule : sldc_host
`default_nettype wire

// ==== verification/serial_lcd_driver_control_bench.sv ====
// Self-checking bench of the serial LCD driver control block
`include "sldc_params.svh"
`default_nettype none
module serial_lcd_driver_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic osc_in;
    int osc_half = 195;
    int osc_cnt = 0;
    int cycles = 0;
    int fails = 0;
    int n_compared = 0;
    logic sel_n, wr_n, rd_n, data_i, data_o, data_oe, flag_n_o, flag_oe, bz_p, bz_n;
    logic lcd_clk, bias_on, bias_third, osc_run;
    logic [`SLDC_RAM_WORDS-1:0] front;
    logic [`SLDC_RAM_BITS-1:0] back;
    logic [1:0] bp_count;
    sldc_top dut (.REF_CLK(clk), .SYS_RST(rst), .SEL_N(sel_n), .WR_N(wr_n),
        .RD_N(rd_n), .DATA_I(data_i), .DATA_O(data_o), .DATA_OE(data_oe), .OSCILLATOR_INPUT(osc_in),
        .FLAG_N_O(flag_n_o), .FLAG_OE(flag_oe), .BUZZER_DRIVE_P(bz_p), .BUZZER_DRIVE_N(bz_n),
        .FRONTPLANE_LINE(front), .BACKPLANE_LINE(back), .LCD_CLK(lcd_clk), .BIAS_ON(bias_on),
        .BIAS_THIRD(bias_third), .BACKPLANE_COUNT(bp_count), .OSC_RUNNING(osc_run));
    sldc_host host (.clk(clk), .sel_n(sel_n), .wr_n(wr_n), .rd_n(rd_n), .data_i(data_i), .data_o(data_o),
        .data_oe(data_oe));
    initial
    begin
        forever #5 clk = ~clk;
    end
    // Roughly 256kHz on the oscillator pin for crystal and external modes
    always @(posedge clk)
    begin
        if (rst || osc_cnt >= osc_half - 1)
        begin
            osc_cnt <= 0;
            osc_in <= rst ? 1'h0 : ~osc_in;
        end
        else
            osc_cnt <= osc_cnt + 1;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            fails++;
            finish_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic finish_test();
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // One command in a frame of its own
    task automatic cmd1(input logic [8:0] c);
        host.sel_pulse();
        host.send_id(`SLDC_ID_CMD);
        host.send_cmd(c);
        repeat (10) @(posedge clk);
    endtask : cmd1
    task automatic t_reset();
        check({bias_third, bp_count, osc_run, bias_on, flag_oe, bz_p, bz_n}, 8'hC0, "reset state");
    endtask : t_reset
    task automatic t_config();
        host.sel_pulse();
        host.send_id(`SLDC_ID_CMD);
        host.send_cmd(`SLDC_CMD_OSC_START_CMD);
        host.send_cmd(`SLDC_CMD_BIAS_GEN_ON_CMD);
        for (int k = 0; k < 6; k++)
        begin
            host.send_cmd({4'h2, k[2:1], 1'h0, k[0], 1'h0});
            repeat (10) @(posedge clk);
            check(bp_count, k[2:1], "backplane count");
            check(bias_third, k[0], "bias option");
        end
        check({osc_run, bias_on}, 2'h3, "start and bias on");
        host.send_cmd(`SLDC_CMD_BIAS_GEN_OFF_CMD);
        repeat (10) @(posedge clk);
        check(bias_on, 1'h0, "bias off");
        host.send_cmd(`SLDC_CMD_BIAS_GEN_ON_CMD);
    endtask : t_config
    task automatic t_ram();
        logic [3:0] v;
        logic [3:0] exp [3] = '{4'hA, 4'hC, 4'h3};
        host.sel_pulse();
        host.send_id(`SLDC_ID_WRITE);
        host.send_addr(6'h1E);
        host.send_nib(4'hA);
        host.send_nib(4'h5);
        host.send_nib(4'h3);
        host.sel_pulse();
        host.send_id(`SLDC_ID_WRITE);
        host.send_addr(6'h1F);
        host.read_nib(v);
        check(v, 4'h5, "modify read");
        host.send_nib(4'hC);
        host.read_nib(v);
        check(v, 4'h3, "wrap to address 0");
        host.sel_pulse();
        host.send_id(`SLDC_ID_READ);
        host.send_addr(6'h1E);
        for (int k = 0; k < 3; k++)
        begin
            host.read_nib(v);
            check(v, exp[k], "read back");
        end
        check(data_oe, 1'h1, "read drive");
        host.sel_pulse();
        check(data_oe, 1'h0, "abort on select");
    endtask : t_ram
    task automatic t_tone();
        int n;
        cmd1(9'h080);
        cmd1(`SLDC_CMD_TONE_ON);
        n = 0;
        while (bz_p !== 1'h1 && n < 30000)
        begin
            @(posedge clk);
            n++;
        end
        check({bz_p, bz_n}, 2'h2, "tone pair");
        cmd1(`SLDC_CMD_TONE_OFF);
        check({bz_p, bz_n}, 2'h0, "tone off");
    endtask : t_tone
    task automatic t_power();
        cmd1(`SLDC_CMD_OSC_POWER_DOWN_CMD);
        check({osc_run, bias_on}, 2'h0, "power down");
        cmd1(9'h038);
        cmd1(`SLDC_CMD_OSC_START_CMD);
        cmd1(`SLDC_CMD_OSC_POWER_DOWN_CMD);
        check(osc_run, 1'h1, "external ignores power down");
        cmd1(9'h028);
        cmd1(`SLDC_CMD_OSC_POWER_DOWN_CMD);
        check(osc_run, 1'h0, "crystal power down");
        cmd1(9'h030);
        // Don't-care bit set
        cmd1(`SLDC_CMD_OSC_START_CMD | 9'h001);
        check(osc_run, 1'h1, "internal source start");
    endtask : t_power
    // Fast external clock: 32kHz tick every 64 cycles, 128 ticks to time base MSB
    task automatic t_timer();
        int n;
        osc_half = 4;
        host.sel_pulse();
        host.send_id(`SLDC_ID_CMD);
        host.send_cmd(9'h038);
        // tick clear before tick and flag pin enable
        host.send_cmd(9'h018);
        host.send_cmd(`SLDC_CMD_TB_EN);
        host.send_cmd(9'h110);
        repeat (4000) @(posedge clk);
        check(flag_oe, 1'h1, "flag pin low in first half");
        n = 0;
        while (flag_oe !== 1'h0 && n < 8000)
        begin
            @(posedge clk);
            n++;
        end
        check(flag_oe, 1'h0, "time base MSB reached");
        cmd1(9'h018);
        check(flag_oe, 1'h1, "tick clear restarts count");
        cmd1(9'h100);
        check(flag_oe, 1'h0, "flag pin disabled");
    endtask : t_timer
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        repeat (10) @(posedge clk);
        t_reset();
        t_config();
        t_ram();
        t_tone();
        t_power();
        t_timer();
        finish_test();
    end
endmodule : serial_lcd_driver_control_bench
`default_nettype wire
